// ===== design/data_ram_pkg.sv
/*
 * Constants for the on-chip data RAM map: sizes, region bounds,
 * reset values of the bank selection and of the stack pointer.
 * Assumes a byte-wide core with a 7-bit internal data address.
 */
package data_ram_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int RAM_BYTES = 128;
    localparam logic [6:0] BANK_BASE = 7'h00;
    localparam logic [6:0] BANK_LAST = 7'h1F;
    localparam logic [6:0] BIT_BASE = 7'h20;
    localparam logic [6:0] BIT_LAST = 7'h2F;
    localparam logic [6:0] SCRATCH_BASE = 7'h30;
    localparam logic [6:0] SCRATCH_LAST = 7'h7F;
    localparam logic [1:0] BANK_RST = 2'h0;
    localparam logic [6:0] STACK_PTR_RST = 7'h07;
    localparam logic [6:0] STACK_PTR_STEP = 7'h01;
    localparam int REG_IDX_W = 3;
    localparam int BIT_POS_W = 3;
    typedef enum logic [1:0] {
        AM_DIRECT,
        AM_INDIRECT,
        AM_REG,
        AM_STACK
    } addr_mode_t;
endpackage

// ===== design/internal_data_ram_map.sv
/*
 * Internal 128-byte data RAM with register banks, a bit-addressable
 * segment, a scratch area and the stack pointer.
 * Assumes the execution logic drives one request per cycle on ref_clk;
 * read data appears in the cycle after the request.
 */
`timescale 1ns/1ns
// Summary of operation
// RULE_01: 128 bytes of RAM, each reached by direct or indirect address.
// RULE_02: Four banks of eight registers occupy addresses 00H to 1FH.
// RULE_03: Reset selects bank 0; software changes it by bank write.
// RULE_04: Stack pointer resets to 07H and increments before each push.
// RULE_05: Bytes 20H-2FH hold 128 individually addressable bits, also bytes.
// RULE_06: Bit n lives in byte 20H plus n/8 at position n mod 8.
// RULE_07: Addresses 30H-7FH are plain RAM and may hold the stack.
// RULE_08: Software using several banks moves the stack into higher RAM.
// RULE_09: Register r resolves to eight times active bank plus r.
module internal_data_ram_map #(
    parameter int DEPTH = data_ram_pkg::RAM_BYTES
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire data_ram_pkg::addr_mode_t req_mode,
    input wire logic req_write,
    input wire logic [6:0] req_addr,
    input wire logic [2:0] req_reg,
    input wire logic [7:0] req_wdata,
    input wire logic [7:0] ptr_value,
    input wire logic bit_valid,
    input wire logic bit_write,
    input wire logic [6:0] bit_num,
    input wire logic bit_wdata,
    input wire logic bank_write,
    input wire logic [1:0] bank_wdata,
    input wire logic stack_load,
    input wire logic [6:0] stack_load_data,
    output logic [7:0] rd_data,
    output logic rd_bit,
    output logic [1:0] bank_sel,
    output logic [6:0] stack_pointer
);
    // ----------------------------------------
    // Storage and state
    // ----------------------------------------
    logic [7:0] mem_r [DEPTH];
    logic [1:0] bank_r, bank_nxt;
    logic [6:0] stack_ptr_r, stack_ptr_nxt;
    logic [7:0] rd_data_r, rd_data_nxt;
    logic rd_bit_r, rd_bit_nxt;
    logic [6:0] eff_addr;
    logic [6:0] bit_byte;
    logic [2:0] bit_pos;
    logic [7:0] bit_merged;
    logic push_now;
    // Single write port of the array, shared by byte and bit writes
    logic mem_we;
    logic [6:0] mem_waddr;
    logic [7:0] mem_wbyte;

    // ----------------------------------------
    // Address resolution
    // ----------------------------------------
    // Effective byte address for each access mode
    always_comb begin
        push_now = req_valid && req_write && (req_mode == data_ram_pkg::AM_STACK);
        case (req_mode)
            data_ram_pkg::AM_DIRECT: eff_addr = req_addr; // [RULE_01]
            data_ram_pkg::AM_INDIRECT: eff_addr = ptr_value[6:0]; // [RULE_01]
            data_ram_pkg::AM_REG: eff_addr = {2'h0, bank_r, req_reg}; // [RULE_09] [RULE_02]
            data_ram_pkg::AM_STACK: begin
                // Push pre-increments, pop reads at the current pointer
                eff_addr = push_now ? (stack_ptr_r + data_ram_pkg::STACK_PTR_STEP)
                                    : stack_ptr_r; // [RULE_04] [RULE_07]
            end
            default: eff_addr = req_addr;
        endcase
    end

    // Bit number splits into byte offset and bit position
    always_comb begin
        bit_byte = data_ram_pkg::BIT_BASE + {3'h0, bit_num[6:3]}; // [RULE_06] [RULE_05]
        bit_pos = bit_num[2:0];
        bit_merged = mem_r[bit_byte];
        bit_merged[bit_pos] = bit_wdata;
    end

    // ----------------------------------------
    // Control registers and read data
    // ----------------------------------------
    // Next values of bank select, stack pointer and read data
    always_comb begin
        bank_nxt = bank_r;
        stack_ptr_nxt = stack_ptr_r;
        rd_data_nxt = rd_data_r;
        rd_bit_nxt = rd_bit_r;
        if (bank_write) begin
            bank_nxt = bank_wdata; // [RULE_03]
        end
        // A pointer load from software beats a push or pop in the same cycle
        if (stack_load) begin
            stack_ptr_nxt = stack_load_data;
        end else if (req_valid && req_mode == data_ram_pkg::AM_STACK) begin
            if (req_write) begin
                stack_ptr_nxt = stack_ptr_r + data_ram_pkg::STACK_PTR_STEP; // [RULE_04]
            end else begin
                stack_ptr_nxt = stack_ptr_r - data_ram_pkg::STACK_PTR_STEP;
            end
        end
        if (req_valid && !req_write) begin
            rd_data_nxt = mem_r[eff_addr]; // [RULE_01]
        end
        if (bit_valid && !bit_write) begin
            rd_bit_nxt = mem_r[bit_byte][bit_pos]; // [RULE_05]
        end
    end

    // Register control state; reset picks bank 0 and pointer 07H
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bank_r <= data_ram_pkg::BANK_RST; // [RULE_03]
            stack_ptr_r <= data_ram_pkg::STACK_PTR_RST; // [RULE_04]
            rd_data_r <= 8'h00;
            rd_bit_r <= 1'b0;
        end else begin
            bank_r <= bank_nxt;
            stack_ptr_r <= stack_ptr_nxt;
            rd_data_r <= rd_data_nxt;
            rd_bit_r <= rd_bit_nxt;
        end
    end

    // ----------------------------------------
    // RAM array
    // ----------------------------------------
    // Write port select: a byte write wins, a bit write in the same cycle is lost
    always_comb begin
        mem_we = 1'b0;
        mem_waddr = eff_addr;
        mem_wbyte = req_wdata;
        if (req_valid && req_write) begin
            mem_we = 1'b1; // [RULE_01] [RULE_07]
        end else if (bit_valid && bit_write) begin
            mem_we = 1'b1; // [RULE_05] [RULE_06]
            mem_waddr = bit_byte;
            mem_wbyte = bit_merged;
        end
    end

    // Array store; no reset branch, so contents survive a reset
    always_ff @(posedge ref_clk) begin
        if (mem_we) begin
            mem_r[mem_waddr] <= mem_wbyte;
        end
    end

    // Outputs straight from the registers
    assign rd_data = rd_data_r;
    assign rd_bit = rd_bit_r;
    assign bank_sel = bank_r;
    assign stack_pointer = stack_ptr_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // Request shapes that the multi-step properties are built from
    sequence s_push;
        req_valid && req_write && req_mode == data_ram_pkg::AM_STACK && !stack_load;
    endsequence

    sequence s_byte_wr;
        req_valid && req_write;
    endsequence

    sequence s_byte_rd_same;
        req_valid && !req_write && eff_addr == $past(eff_addr);
    endsequence

    sequence s_bit_wr;
        bit_valid && bit_write && !req_valid;
    endsequence

    sequence s_bit_rd_same;
        bit_valid && !bit_write && !req_valid && bit_num == $past(bit_num);
    endsequence

    // Reset values of the control state
    a_reset_bank: assert property (@(posedge ref_clk) // [RULE_03]
        !rst_n |=> bank_sel == data_ram_pkg::BANK_RST)
        else $error("bank not zero after reset");
    a_reset_ptr: assert property (@(posedge ref_clk) // [RULE_04]
        !rst_n |=> stack_pointer == data_ram_pkg::STACK_PTR_RST)
        else $error("stack pointer not 07H after reset");

    // Pointer and bank movement
    a_push_preinc: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE_04]
        s_push |=> stack_pointer == $past(stack_pointer) + data_ram_pkg::STACK_PTR_STEP)
        else $error("push did not pre-increment pointer");
    a_bank_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE_03]
        !bank_write |=> $stable(bank_sel))
        else $error("bank changed without software write");

    // Address mapping of register operands and bit numbers
    a_reg_addr: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE_09]
        req_valid && req_mode == data_ram_pkg::AM_REG
        |-> eff_addr == 7'(bank_sel) * 7'h08 + 7'(req_reg)
        && eff_addr <= data_ram_pkg::BANK_LAST)
        else $error("register operand mis-resolved");
    a_bit_map: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE_06]
        bit_valid |-> bit_byte >= data_ram_pkg::BIT_BASE && bit_byte <= data_ram_pkg::BIT_LAST
        && bit_byte == data_ram_pkg::BIT_BASE + bit_num / 7'h08)
        else $error("bit number mapped to wrong byte");

    // Write followed at once by a read of the same place returns the new value
    a_byte_rdback: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE_01]
        s_byte_wr ##1 s_byte_rd_same |=> rd_data == $past(req_wdata, 2))
        else $error("byte read-back mismatch");
    a_bit_rdback: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE_05]
        s_bit_wr ##1 s_bit_rd_same |=> rd_bit == $past(bit_wdata, 2))
        else $error("bit read-back mismatch");

    // Read results stand until the next read of their kind
    a_rd_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE_01]
        !(req_valid && !req_write) |=> $stable(rd_data))
        else $error("byte read data changed without a read");
    a_bit_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE_05]
        !(bit_valid && !bit_write) |=> $stable(rd_bit))
        else $error("bit read data changed without a read");
endmodule

// ===== sim/exec_driver.sv
/* Stand-in for the execution logic: issues byte, bit, bank and pointer requests.
   Assumes ref_clk runs freely; lines change only on falling edges. */
`timescale 1ns/1ns
module exec_driver (
    input wire logic ref_clk,
    output data_ram_pkg::addr_mode_t req_mode,
    output logic req_valid,
    output logic req_write,
    output logic bit_valid,
    output logic bit_write,
    output logic bit_wdata,
    output logic bank_write,
    output logic stack_load,
    output logic [6:0] req_addr,
    output logic [6:0] bit_num,
    output logic [6:0] stack_load_data,
    output logic [7:0] req_wdata,
    output logic [7:0] ptr_value,
    output logic [2:0] req_reg,
    output logic [1:0] bank_wdata
);
    // Idle lines at time zero
    initial begin
        {req_valid, req_write, bit_valid, bit_write, bit_wdata, bank_write, stack_load} = 7'h00;
        req_mode = data_ram_pkg::AM_DIRECT;
        {req_addr, bit_num, stack_load_data, req_wdata, ptr_value, req_reg, bank_wdata} = '0;
    end
    // Puts one request on the lines; called just after a falling edge
    task automatic put(input logic [3:0] kind, input data_ram_pkg::addr_mode_t mode,
                       input logic wr, input logic [6:0] a, input logic [7:0] d);
        {req_valid, bit_valid, bank_write, stack_load} = kind;
        req_mode = mode;
        {req_write, bit_write, bit_wdata, bank_wdata} = {wr, wr, d[0], d[1:0]};
        {req_addr, bit_num, stack_load_data, req_reg} = {a, a, a, a[2:0]};
        ptr_value = {~a[0], a};  // Top bit carries noise
        req_wdata = d;
    endtask
    // Drops every strobe; released bus does not keep the last byte
    task automatic drop_lines(input logic [7:0] d);
        {req_valid, bit_valid, bank_write, stack_load} = 4'h0;
        req_wdata = ~d;
    endtask
    // Holds one request over one rising edge, then releases it
    task automatic issue(input logic [3:0] kind, input data_ram_pkg::addr_mode_t mode,
                         input logic wr, input logic [6:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        put(kind, mode, wr, a, d);
        @(negedge ref_clk);
        drop_lines(d);
    endtask
    // Write then read of one operand on two back-to-back rising edges
    task automatic issue_pair(input logic [3:0] kind, input data_ram_pkg::addr_mode_t wmode,
                              input data_ram_pkg::addr_mode_t rmode, input logic [6:0] a,
                              input logic [7:0] d);
        @(negedge ref_clk);
        put(kind, wmode, 1'b1, a, d);
        @(negedge ref_clk);
        put(kind, rmode, 1'b0, a, d);
        @(negedge ref_clk);
        drop_lines(d);
    endtask
endmodule

// ===== sim/internal_data_ram_map_test.sv
/* Self-checking bench for the data RAM map with a reference model.
   Assumes exec_driver drives every request input. */
`timescale 1ns/1ns
module internal_data_ram_map_test;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    data_ram_pkg::addr_mode_t req_mode;
    logic req_valid, req_write, bit_valid, bit_write, bit_wdata, bank_write, stack_load, rd_bit;
    logic [6:0] req_addr, bit_num, stack_load_data, stack_pointer;
    logic [7:0] req_wdata, ptr_value, rd_data, mem[128];
    logic [2:0] req_reg;
    logic [1:0] bank_wdata, bank_sel;
    logic [31:0] seed = 32'h26B7BE23;
    int n_errors = 0, n_compared = 0, cycles = 0, bank = 0, ptr_model = 7;
    internal_data_ram_map uut (.ref_clk, .rst_n, .req_valid, .req_mode, .req_write, .req_addr,
        .req_reg, .req_wdata, .ptr_value, .bit_valid, .bit_write, .bit_num, .bit_wdata,
        .bank_write, .bank_wdata, .stack_load, .stack_load_data, .rd_data, .rd_bit, .bank_sel,
        .stack_pointer);
    exec_driver drv (.ref_clk, .req_mode, .req_valid, .req_write, .bit_valid, .bit_write,
        .bit_wdata, .bank_write, .stack_load, .req_addr, .bit_num, .stack_load_data, .req_wdata,
        .ptr_value, .req_reg, .bank_wdata);
    // Clock and hang limit
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            report_and_stop();
        end
    end
    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Byte request with model update and read-back compare
    task automatic op(input data_ram_pkg::addr_mode_t m, input logic wr, input int a,
                      input logic [7:0] d);
        int ea;
        ea = (m == data_ram_pkg::AM_REG) ? bank * 8 + a % 8 : a;
        if (m == data_ram_pkg::AM_STACK) begin
            ptr_model = wr ? ptr_model + 1 : ptr_model;
            ea = ptr_model;
        end
        drv.issue(4'h8, m, wr, 7'(a), d);
        if (wr) mem[ea] = d;
        else check(rd_data, mem[ea]);
        if (m == data_ram_pkg::AM_STACK && !wr) ptr_model = ptr_model - 1;
        check(8'(stack_pointer), 8'(ptr_model));
    endtask
    // Back-to-back byte write and read of one address, one direct and one indirect
    task automatic pair(input logic ind, input int a, input logic [7:0] d);
        drv.issue_pair(4'h8, ind ? data_ram_pkg::AM_INDIRECT : data_ram_pkg::AM_DIRECT,
                       ind ? data_ram_pkg::AM_DIRECT : data_ram_pkg::AM_INDIRECT, 7'(a), d);
        mem[a] = d;
        check(rd_data, mem[a]);
    endtask
    // Back-to-back bit write and read of one bit number
    task automatic bpair(input int n, input logic v);
        drv.issue_pair(4'h4, data_ram_pkg::AM_DIRECT, data_ram_pkg::AM_DIRECT, 7'(n),
                       {7'h00, v});
        mem[32 + n / 8][n % 8] = v;
        check({7'h00, rd_bit}, {7'h00, mem[32 + n / 8][n % 8]});
    endtask
    task automatic bop(input logic wr, input int n, input logic v);
        drv.issue(4'h4, data_ram_pkg::AM_DIRECT, wr, 7'(n), {7'h00, v});
        if (wr) mem[32 + n / 8][n % 8] = v;
        else check({7'h00, rd_bit}, {7'h00, mem[32 + n / 8][n % 8]});
    endtask
    task automatic report_and_stop();
        $display("errors=%0d compared=%0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Main sequence
    initial begin
        int a;
        repeat (3) @(negedge ref_clk);
        rst_n = 1'b1;
        check(8'(bank_sel), 8'h00);
        check(8'(stack_pointer), 8'h07);
        op(data_ram_pkg::AM_STACK, 1'b1, 0, 8'h55);
        op(data_ram_pkg::AM_DIRECT, 1'b0, 8, 8'h00);
        for (int i = 0; i < 32; i++) begin
            a = int'(xs() % 128);
            op(i % 2 ? data_ram_pkg::AM_DIRECT : data_ram_pkg::AM_INDIRECT, 1'b1, a, 8'(xs()));
            op(i % 2 ? data_ram_pkg::AM_INDIRECT : data_ram_pkg::AM_DIRECT, 1'b0, a, 8'h00);
        end
        for (int i = 0; i < 8; i++) begin
            pair(1'(i % 2), int'(xs() % 128), 8'(xs()));
        end
        for (int b = 0; b < 4; b++) begin
            drv.issue(4'h2, data_ram_pkg::AM_DIRECT, 1'b1, 7'h00, 8'(b));
            bank = b;
            check(8'(bank_sel), 8'(b));
            op(data_ram_pkg::AM_REG, 1'b1, 7 - b, 8'(xs()));
            op(data_ram_pkg::AM_DIRECT, 1'b0, b * 8 + 7 - b, 8'h00);
        end
        // Reset in mid-run: bank and pointer return, RAM keeps its bytes
        @(negedge ref_clk);
        rst_n = 1'b0;
        repeat (3) @(negedge ref_clk);
        rst_n = 1'b1;
        bank = 0;
        ptr_model = 7;
        check(8'(bank_sel), 8'h00);
        check(8'(stack_pointer), 8'h07);
        op(data_ram_pkg::AM_DIRECT, 1'b0, 3 * 8 + 4, 8'h00);
        for (a = 32; a < 48; a++) op(data_ram_pkg::AM_DIRECT, 1'b1, a, 8'(xs()));
        for (int i = 0; i < 24; i++) begin
            a = i == 0 ? 9 : int'(xs() % 128);
            bop(1'b1, a, xs() % 2 == 1);
            bop(1'b0, a, 1'b0);
            op(data_ram_pkg::AM_DIRECT, 1'b0, 32 + a / 8, 8'h00);
        end
        for (int i = 0; i < 8; i++) bpair(int'(xs() % 128), xs() % 2 == 1);
        drv.issue(4'h1, data_ram_pkg::AM_DIRECT, 1'b1, 7'h5F, 8'h00);
        ptr_model = 'h5F;
        op(data_ram_pkg::AM_STACK, 1'b1, 0, 8'hAA);
        op(data_ram_pkg::AM_STACK, 1'b0, 0, 8'h00);
        report_and_stop();
    end
endmodule
